// ===== core/pafm_defines.svh
`ifndef PAFM_DEFINES_SVH
`define PAFM_DEFINES_SVH
// Overview of operation
// RULE1: Operation on input port uses pins, writes latch
// RULE2: Reset clears every output latch
// RULE3: Alternate inputs need direction bit one
// RULE4: Alternate outputs need direction zero, latch zero
// RULE5: Serial transmit needs direction zero, latch one
// RULE6: Two-wire pins need direction and latch zero
// RULE7: Analog pins need direction one, own selects
// RULE8: Oscillator pins follow clock pin mode register
// RULE9: Serial reroute active only when bit two set
// RULE10: Rerouted clock out zero/one, in one/any
// RULE11: Input-mode write hits latch, read returns pin
// RULE12: Bit instruction: read byte, modify, write byte
// RULE13: Write-back may copy pin levels into latches
// RULE14: Software rewrites latch before input-to-output switch
// RULE15: Direction zero drives, one releases; read selects
// RULE16: Enabled peripheral output replaces latch on pin

// ------------------------------------------------------------
// Register byte addresses (one aligned word each)
// ------------------------------------------------------------
`define PAFM_LATCH_BASE   8'h00
`define PAFM_DIR_BASE     8'h20
`define PAFM_GRP_MASK     8'hE0
`define PAFM_IDX          4:2
`define PAFM_CMD_ADDR     8'h40
`define PAFM_CLKMODE_ADDR 8'h44
`define PAFM_REROUTE_ADDR 8'h48
`define PAFM_ANACFG_ADDR  8'h4C
`define PAFM_CHSEL_ADDR   8'h50
`define PAFM_AMPEN_ADDR   8'h54

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PAFM_LATCH_RST    8'h00
`define PAFM_DIR_RST      8'hFF
`define PAFM_CLKMODE_RST  8'h00
`define PAFM_REROUTE_RST  8'h00
`define PAFM_ANACFG_RST   5'h10
`define PAFM_CHSEL_RST    8'h00
`define PAFM_AMPEN_RST    3'h0

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PAFM_REROUTE_BIT  2
`define PAFM_CLK_OSC_BIT  6
`define PAFM_CLK_EXT_BIT  7
`define PAFM_CMD_BIT      2:0
`define PAFM_CMD_PORT     6:4
`define PAFM_CMD_OP       10:8
`define PAFM_CMD_OPND     23:16
`define PAFM_ANACFG_W     5
`define PAFM_AMPEN_W      3

`endif

// ===== core/pafm_pkg.sv
package pafm_pkg;

	// Read-modify-write sequencer states
	typedef enum logic [1:0] {
		PAFM_IDLE,
		PAFM_RD,
		PAFM_MOD,
		PAFM_WR
	} pafm_state_t;

	// Port operations started through the command register
	typedef enum logic [2:0] {
		PAFM_OP_SET1,
		PAFM_OP_CLR1,
		PAFM_OP_NOT1,
		PAFM_OP_AND,
		PAFM_OP_OR,
		PAFM_OP_XOR,
		PAFM_OP_ADD
	} pafm_op_t;

endpackage : pafm_pkg

// ===== core/pafm_port_mux.sv
`timescale 1ns/1ps
`include "pafm_defines.svh"

module pafm_port_mux import pafm_pkg::*; #(
	parameter int NPORT    = 4,
	parameter int X1_PIN   = 25,
	parameter int X2_PIN   = 26,
	parameter int SCLK_PRI = 16,
	parameter int SCLK_ALT = 9,
	parameter int SIN_PRI  = 17,
	parameter int SIN_ALT  = 10,
	parameter logic [NPORT*8-1:0] AND_MASK = '0
) (
	input  wire logic                  sys_clk_i,          // System clock
	input  wire logic                  sys_rst_i,          // Async reset, high
	input  wire logic                  ce_i,               // Clock enable
	input  wire logic [7:0]            avs_address_i,      // Byte address
	input  wire logic                  avs_read_i,         // Read request
	input  wire logic                  avs_write_i,        // Write request
	input  wire logic [3:0]            avs_byteenable_i,   // Byte lanes
	input  wire logic [31:0]           avs_writedata_i,    // Write data
	output logic      [31:0]           avs_readdata_o,     // Read data
	output logic                       avs_waitrequest_o,  // Stall
	input  wire logic [NPORT*8-1:0]    pin_in_i,           // Pad levels
	output logic      [NPORT*8-1:0]    pin_out_o,          // Pad drive value
	output logic      [NPORT*8-1:0]    pin_oe_n_o,         // Pad enable, low
	input  wire logic [NPORT*8-1:0]    alt_en_i,           // Peripheral owns pin
	input  wire logic [NPORT*8-1:0]    alt_out_i,          // Peripheral output
	output logic      [NPORT*8-1:0]    alt_in_o,           // Synced pin levels
	output logic      [7:0]            clock_pin_mode_o,   // Clock pin mode
	output logic                       serial_reroute_o,   // Reroute active
	output logic                       clocked_serial_clock_o, // Routed clock in
	output logic                       clocked_serial_in_o,    // Routed data in
	output logic [`PAFM_ANACFG_W-1:0]  analog_pin_config_o,    // Analog pin cfg
	output logic      [7:0]            converter_channel_select_o, // Channel
	output logic [`PAFM_AMPEN_W-1:0]   amplifier_enable_o  // Amplifier enables
);

	localparam int NB = NPORT * 8;
	localparam logic [2:0] LAST = 3'(NPORT - 1);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (NPORT < 1 || NPORT > 8) begin : g_bad_nport
		$error("NPORT must be 1 to 8");
	end
	if (X1_PIN >= NB || X2_PIN >= NB || SCLK_PRI >= NB || SCLK_ALT >= NB ||
	    SIN_PRI >= NB || SIN_ALT >= NB) begin : g_bad_pin
		$error("Pin index outside the ports");
	end

	// Byte of a port-wide vector; an absent port reads zero
	function automatic logic [7:0] pafm_byte(input logic [NB-1:0] v,
	                                         input logic [2:0] i);
		if (i > LAST) begin
			return 8'h00;
		end
		return v[int'(i)*8 +: 8];
	endfunction : pafm_byte

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [NB-1:0]             pin_s1_q;
	logic [NB-1:0]             pin_s2_q;
	logic [NB-1:0]             latch_q;
	logic [NB-1:0]             dir_q;
	logic [NB-1:0]             pin_out_q;
	logic [NB-1:0]             oe_n_q;
	logic [7:0]                clkmode_q;
	logic [7:0]                reroute_q;
	logic [`PAFM_ANACFG_W-1:0] anacfg_q;
	logic [7:0]                chsel_q;
	logic [`PAFM_AMPEN_W-1:0]  ampen_q;
	pafm_state_t               state_q;
	logic                      wait_q;
	logic [31:0]               rdata_q;
	logic [7:0]                rmw_q;
	logic [2:0]                cmd_bit_q;
	logic [2:0]                cmd_port_q;
	pafm_op_t                  cmd_op_q;
	logic [7:0]                cmd_opnd_q;
	logic                      sclk_q;
	logic                      sin_q;

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	// Pads are asynchronous; only the second stage is looked at
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else if (ce_i) begin
			pin_s1_q <= pin_in_i;
			pin_s2_q <= pin_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Pin ownership and read view
	// ------------------------------------------------------------
	// Oscillator mode takes both clock pins, or only the second when the external clock bit is also set
	wire           osc_x1   = clkmode_q[`PAFM_CLK_OSC_BIT] & ~clkmode_q[`PAFM_CLK_EXT_BIT];
	wire           osc_x2   = clkmode_q[`PAFM_CLK_OSC_BIT];
	wire [NB-1:0]  osc_mask = (NB'(osc_x1) << X1_PIN) | (NB'(osc_x2) << X2_PIN); // RULE8
	// Input bits show the pin, output bits the latch; clock pins taken by oscillator mode read zero
	wire [NB-1:0]  rd_view  = ((dir_q & pin_s2_q) | (~dir_q & latch_q)) & ~osc_mask; // RULE15 RULE11
	// Latch zero lets an OR-combined peripheral through, latch one an AND one
	wire [NB-1:0]  alt_mix  = (AND_MASK & alt_out_i & latch_q) |
	                          (~AND_MASK & (alt_out_i | latch_q)); // RULE4 RULE5 RULE6 RULE10
	wire [NB-1:0]  out_d    = (alt_en_i & alt_mix) | (~alt_en_i & latch_q); // RULE16
	wire [NB-1:0]  oe_n_d   = dir_q | osc_mask; // RULE15 RULE8
	wire           sclk_d   = reroute_q[`PAFM_REROUTE_BIT] ? pin_s2_q[SCLK_ALT]
	                                                       : pin_s2_q[SCLK_PRI]; // RULE9
	wire           sin_d    = reroute_q[`PAFM_REROUTE_BIT] ? pin_s2_q[SIN_ALT]
	                                                       : pin_s2_q[SIN_PRI]; // RULE9

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire [2:0] idx      = avs_address_i[`PAFM_IDX];
	wire       idx_ok   = idx <= LAST;
	wire       acc      = (state_q == PAFM_IDLE) && wait_q && (avs_read_i || avs_write_i);
	wire       wr_acc   = acc && avs_write_i && avs_byteenable_i[0];
	wire       is_latch = ((avs_address_i & `PAFM_GRP_MASK) == `PAFM_LATCH_BASE) && idx_ok;
	wire       is_dir   = ((avs_address_i & `PAFM_GRP_MASK) == `PAFM_DIR_BASE) && idx_ok;
	wire       is_cmd   = avs_address_i == `PAFM_CMD_ADDR;
	wire       cmd_go   = wr_acc && is_cmd;
	wire       rmw_wr   = state_q == PAFM_WR;
	wire [7:0] rd_cmd_byte = pafm_byte(rd_view, cmd_port_q);
	wire [7:0] bit_mask = 8'h01 << cmd_bit_q;

	// Read multiplexer; unmapped addresses answer zero
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (is_latch) begin
			rd_byte = pafm_byte(rd_view, idx); // RULE11
		end else if (is_dir) begin
			rd_byte = pafm_byte(dir_q, idx);
		end else if (is_cmd) begin
			rd_byte = rmw_q;
		end else if (avs_address_i == `PAFM_CLKMODE_ADDR) begin
			rd_byte = clkmode_q;
		end else if (avs_address_i == `PAFM_REROUTE_ADDR) begin
			rd_byte = reroute_q;
		end else if (avs_address_i == `PAFM_ANACFG_ADDR) begin
			rd_byte = {3'h0, anacfg_q};
		end else if (avs_address_i == `PAFM_CHSEL_ADDR) begin
			rd_byte = chsel_q;
		end else if (avs_address_i == `PAFM_AMPEN_ADDR) begin
			rd_byte = {5'h00, ampen_q};
		end
	end

	// Modify step of the port operation
	logic [7:0] alu_res;
	always_comb begin
		alu_res = rmw_q;
		case (cmd_op_q)
			PAFM_OP_SET1: alu_res = rmw_q | bit_mask;
			PAFM_OP_CLR1: alu_res = rmw_q & ~bit_mask;
			PAFM_OP_NOT1: alu_res = rmw_q ^ bit_mask;
			PAFM_OP_AND:  alu_res = rmw_q & cmd_opnd_q;
			PAFM_OP_OR:   alu_res = rmw_q | cmd_opnd_q;
			PAFM_OP_XOR:  alu_res = rmw_q ^ cmd_opnd_q;
			PAFM_OP_ADD:  alu_res = rmw_q + cmd_opnd_q;
			default:      alu_res = rmw_q;
		endcase
	end

	// ------------------------------------------------------------
	// Handshake and read-modify-write sequencer
	// ------------------------------------------------------------
	// Waitrequest idles high so that a request is never taken twice
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= PAFM_IDLE;
			wait_q  <= 1'b1;
		end else if (ce_i) begin
			case (state_q)
				PAFM_IDLE: begin
					if (!wait_q) begin
						wait_q <= 1'b1;
					end else if (cmd_go) begin
						state_q <= PAFM_RD; // RULE12
					end else if (acc) begin
						wait_q <= 1'b0;
					end
				end
				PAFM_RD:  state_q <= PAFM_MOD;
				PAFM_MOD: state_q <= PAFM_WR;
				PAFM_WR: begin
					state_q <= PAFM_IDLE;
					wait_q  <= 1'b0;
				end
				default:  state_q <= PAFM_IDLE;
			endcase
		end
	end

	// Command capture and working byte
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cmd_bit_q  <= 3'h0;
			cmd_port_q <= 3'h0;
			cmd_op_q   <= PAFM_OP_SET1;
			cmd_opnd_q <= 8'h00;
		end else if (ce_i && cmd_go) begin
			cmd_bit_q  <= avs_writedata_i[`PAFM_CMD_BIT];
			cmd_port_q <= avs_writedata_i[`PAFM_CMD_PORT];
			cmd_op_q   <= pafm_op_t'(avs_writedata_i[`PAFM_CMD_OP]);
			cmd_opnd_q <= avs_writedata_i[`PAFM_CMD_OPND];
		end
	end

	// Whole byte is read, so input bits pick up their pin levels
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rmw_q <= 8'h00;
		end else if (ce_i && state_q == PAFM_RD) begin
			rmw_q <= rd_cmd_byte; // RULE1 RULE12 RULE13
		end else if (ce_i && state_q == PAFM_MOD) begin
			rmw_q <= alu_res; // RULE12
		end
	end

	// Read data is captured at the accept edge
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (ce_i && acc && avs_read_i) begin
			rdata_q <= {24'h00_0000, rd_byte};
		end
	end

	// ------------------------------------------------------------
	// Port latches and directions
	// ------------------------------------------------------------
	for (genvar g = 0; g < NPORT; g++) begin : g_port
		// The whole byte is written back, untouched bits included
		always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				latch_q[g*8 +: 8] <= `PAFM_LATCH_RST; // RULE2
			end else if (ce_i && wr_acc && is_latch && idx == 3'(g)) begin
				latch_q[g*8 +: 8] <= avs_writedata_i[7:0]; // RULE11
			end else if (ce_i && rmw_wr && cmd_port_q == 3'(g)) begin
				latch_q[g*8 +: 8] <= rmw_q; // RULE12 RULE13
			end
		end
		// Pins come up as inputs so nothing is driven before software acts
		always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				dir_q[g*8 +: 8] <= `PAFM_DIR_RST;
			end else if (ce_i && wr_acc && is_dir && idx == 3'(g)) begin
				dir_q[g*8 +: 8] <= avs_writedata_i[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			clkmode_q <= `PAFM_CLKMODE_RST; // RULE8
			reroute_q <= `PAFM_REROUTE_RST;
			anacfg_q  <= `PAFM_ANACFG_RST;
			chsel_q   <= `PAFM_CHSEL_RST;
			ampen_q   <= `PAFM_AMPEN_RST;
		end else if (ce_i && wr_acc) begin
			if (avs_address_i == `PAFM_CLKMODE_ADDR) begin
				clkmode_q <= avs_writedata_i[7:0];
			end else if (avs_address_i == `PAFM_REROUTE_ADDR) begin
				reroute_q <= avs_writedata_i[7:0]; // RULE9
			end else if (avs_address_i == `PAFM_ANACFG_ADDR) begin
				anacfg_q <= avs_writedata_i[`PAFM_ANACFG_W-1:0]; // RULE7
			end else if (avs_address_i == `PAFM_CHSEL_ADDR) begin
				chsel_q <= avs_writedata_i[7:0]; // RULE7
			end else if (avs_address_i == `PAFM_AMPEN_ADDR) begin
				ampen_q <= avs_writedata_i[`PAFM_AMPEN_W-1:0]; // RULE7
			end
		end
	end

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	// Registered pads cost a cycle but keep pad timing clean
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_out_q <= '0;
			oe_n_q    <= '1;
			sclk_q    <= 1'b0;
			sin_q     <= 1'b0;
		end else if (ce_i) begin
			pin_out_q <= out_d; // RULE16
			oe_n_q    <= oe_n_d; // RULE15
			sclk_q    <= sclk_d; // RULE10
			sin_q     <= sin_d;
		end
	end

	assign avs_readdata_o             = rdata_q;
	assign avs_waitrequest_o          = wait_q;
	assign pin_out_o                  = pin_out_q;
	assign pin_oe_n_o                 = oe_n_q;
	assign alt_in_o                   = pin_s2_q; // RULE3
	assign clock_pin_mode_o           = clkmode_q;
	assign serial_reroute_o           = reroute_q[`PAFM_REROUTE_BIT];
	assign clocked_serial_clock_o     = sclk_q;
	assign clocked_serial_in_o        = sin_q;
	assign analog_pin_config_o        = anacfg_q; // RULE7
	assign converter_channel_select_o = chsel_q;
	assign amplifier_enable_o         = ampen_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i || !ce_i);

	rmw_sequence_a: assert property (state_q == PAFM_RD |=> state_q == PAFM_MOD ##1 // RULE12
		state_q == PAFM_WR ##1 (state_q == PAFM_IDLE && !avs_waitrequest_o))
		else $error("Port operation did not run read, modify, write");

	rmw_read_a: assert property (state_q == PAFM_RD |=> rmw_q == $past(rd_cmd_byte)) // RULE1
		else $error("Port operation did not read the pin view");

	rmw_writeback_a: assert property ((rmw_wr && cmd_port_q <= LAST) |=> // RULE13
		pafm_byte(latch_q, cmd_port_q) == $past(rmw_q))
		else $error("Whole byte was not written back to the latch");

	reset_latch_a: assert property ($fell(sys_rst_i) |-> latch_q == '0) // RULE2
		else $error("Latches not cleared by reset");

	input_read_a: assert property ((acc && avs_read_i && is_latch && idx == 3'h0 && // RULE11
		dir_q[0] && !osc_mask[0]) |=> avs_readdata_o[0] == $past(pin_s2_q[0]))
		else $error("Input-mode bit does not read the pin");

	drive_enable_a: assert property ((!dir_q[0] && !osc_mask[0]) |=> !pin_oe_n_o[0]) // RULE15
		else $error("Output-mode pin not driven");

	osc_release_a: assert property (clkmode_q[`PAFM_CLK_OSC_BIT] |-> // RULE8
		!rd_view[X2_PIN] ##1 pin_oe_n_o[X2_PIN])
		else $error("Clock pin not released in oscillator mode");

	reroute_off_a: assert property (!reroute_q[`PAFM_REROUTE_BIT] |=> // RULE9
		clocked_serial_clock_o == $past(pin_s2_q[SCLK_PRI]))
		else $error("Serial clock rerouted without select bit");

	alt_output_a: assert property (((alt_en_i & ~latch_q & ~AND_MASK) != '0) |=> // RULE16
		((pin_out_o ^ $past(alt_out_i)) & $past(alt_en_i) & ~$past(latch_q) & ~AND_MASK) == '0)
		else $error("Peripheral output not passed to pin");

	plain_answer_a: assert property ((acc && !cmd_go) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("Plain access not answered in one cycle");

	rmw_done_c:   cover property (rmw_wr ##1 !avs_waitrequest_o);
	bus_read_c:   cover property (acc && avs_read_i && is_latch);
	osc_mode_c:   cover property (clkmode_q[`PAFM_CLK_OSC_BIT]);
	reroute_on_c: cover property (reroute_q[`PAFM_REROUTE_BIT] && alt_en_i != '0);

endmodule : pafm_port_mux

// ===== verif/pafm_pin_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Pad wires with outside drivers
// ------------------------------------------------
module pafm_pin_model #(
	parameter int W = 32
) (
	input  wire logic [W-1:0] pin_out_i,   // Device drive value
	input  wire logic [W-1:0] pin_oe_n_i,  // Device enable, low
	input  wire logic [W-1:0] ext_level_i, // Outside driver level
	output logic      [W-1:0] pad_o        // Wire level
);
	// Outside drivers back off where the device drives, so no bus fight
	assign pad_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & ext_level_i);
endmodule : pafm_pin_model

// ===== verif/tb.sv
`timescale 1ns/1ps
`include "pafm_defines.svh"

module tb import pafm_pkg::*;;
	localparam int          X1    = 25;
	localparam int          X2    = 26;
	localparam logic [31:0] AMASK = 32'h0000_0201;
	logic        clk, rst, rd, wr, wreq, rr_o, sck, sin, rr, ce;
	logic [7:0]  adr, cm_o, ch_o, cm;
	logic [3:0]  be;
	logic [4:0]  ana_o;
	logic [2:0]  amp_o;
	logic [31:0] wd, rdata, pout, poe, ain, pad, ext, aen, aout, q, d;
	logic [7:0]  lat[4];
	logic [7:0]  dir[4];
	logic [7:0]  al[3] = '{8'h01, 8'h02, 8'h00};
	logic [7:0]  ad[3] = '{8'h00, 8'hFD, 8'hFC};
	logic [7:0]  msk[3] = '{8'h1F, 8'hFF, 8'h07};
	logic [1:0]  p;
	int          err_count, checked, k;

	pafm_port_mux #(.X1_PIN(X1), .X2_PIN(X2), .AND_MASK(AMASK)) pafm_port_mux_inst (
		.sys_clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wd),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .pin_in_i(pad), .pin_out_o(pout),
		.pin_oe_n_o(poe), .alt_en_i(aen), .alt_out_i(aout), .alt_in_o(ain),
		.clock_pin_mode_o(cm_o), .serial_reroute_o(rr_o), .clocked_serial_clock_o(sck),
		.clocked_serial_in_o(sin), .analog_pin_config_o(ana_o),
		.converter_channel_select_o(ch_o), .amplifier_enable_o(amp_o));

	pafm_pin_model #(.W(32)) pafm_pin_model_inst (
		.pin_out_i(pout), .pin_oe_n_i(poe), .ext_level_i(ext), .pad_o(pad));

	// ------------------------------------------------
	// Reference model of latches, directions and pads
	// ------------------------------------------------
	function automatic logic [31:0] tk();
		tk = '0;
		if (cm[6]) begin
			tk[X2] = 1'b1;
			tk[X1] = ~cm[7];
		end
	endfunction : tk
	function automatic logic [31:0] lv();
		lv = {lat[3], lat[2], lat[1], lat[0]};
	endfunction : lv
	function automatic logic [31:0] eoe();
		eoe = {dir[3], dir[2], dir[1], dir[0]} | tk();
	endfunction : eoe
	function automatic logic [31:0] eout();
		eout = (aen & ((AMASK & aout & lv()) | (~AMASK & (aout | lv())))) | (~aen & lv());
	endfunction : eout
	function automatic logic [31:0] epad();
		epad = (~eoe() & eout()) | (eoe() & ext);
	endfunction : epad
	function automatic logic [31:0] view();
		view = ~tk() & ((eoe() & epad()) | (~eoe() & lv()));
	endfunction : view

	// ------------------------------------------------
	// Bus master, comparison and checks
	// ------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("BAD t=%0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dd,
		input logic [3:0] b, output logic [31:0] r);
		int n;
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		adr <= a;
		wd <= dd;
		be <= b;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (wreq !== 1'b0) err_count++;
	endtask : bus
	task automatic wrt(input logic [7:0] a, input logic [31:0] dd);
		logic [31:0] r;
		bus(1'b1, a, dd, 4'hF, r);
	endtask : wrt
	task automatic rdb(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, 4'hF, r);
	endtask : rdb
	task automatic check_all();
		logic [31:0] v, e;
		repeat (6) @(posedge clk);
		v = view();
		e = epad();
		for (int i = 0; i < 4; i++) begin
			rdb(`PAFM_LATCH_BASE + 8'(4 * i), q);
			chk(q, {24'h0, v[8*i+:8]});
			rdb(`PAFM_DIR_BASE + 8'(4 * i), q);
			chk(q, {24'h0, dir[i]});
		end
		chk(poe, eoe());
		chk(pout & ~eoe(), eout() & ~eoe());
		chk(ain, e);
		chk({30'h0, sck, sin}, {30'h0, e[rr ? 9 : 16], e[rr ? 10 : 17]});
		chk({23'h0, rr_o, cm_o}, {23'h0, rr, cm});
	endtask : check_all
	task automatic cmd(input logic [1:0] pp, input logic [2:0] b, input logic [2:0] op,
		input logic [7:0] o);
		logic [31:0] vw;
		logic [7:0]  v;
		vw = view();
		v = vw[8*pp+:8];
		case (pafm_op_t'(op))
			PAFM_OP_SET1: v[b] = 1'b1;
			PAFM_OP_CLR1: v[b] = 1'b0;
			PAFM_OP_NOT1: v[b] = ~v[b];
			PAFM_OP_AND:  v = v & o;
			PAFM_OP_OR:   v = v | o;
			PAFM_OP_XOR:  v = v ^ o;
			PAFM_OP_ADD:  v = v + o;
			default: ;
		endcase
		wrt(`PAFM_CMD_ADDR, {8'h00, o, 5'h00, op, 2'b00, pp, 1'b0, b});
		lat[pp] = v;
		rdb(`PAFM_CMD_ADDR, q);
		chk(q, {24'h0, v});
	endtask : cmd
	task automatic do_rst();
		@(posedge clk);
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			lat[i] = 8'h00;
			dir[i] = 8'hFF;
		end
		cm = 8'h00;
		rr = 1'b0;
	endtask : do_rst
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	// ------------------------------------------------
	// Clock, watchdog and test sequence
	// ------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Whole sequence needs well under this span; a hang ends here
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		end_sim();
	end
	initial begin
		{rst, rd, wr, adr, be, wd, aen, aout} = '0;
		rst = 1'b1;
		ce = 1'b1;
		k = $urandom(32'h48E29F79);
		ext = $urandom;
		do_rst();
		check_all();
		rdb(`PAFM_ANACFG_ADDR, q);
		chk(q, 32'h10);
		chk({16'h0, ana_o, ch_o, amp_o}, {16'h0, 5'h10, 8'h00, 3'h0});
		// Port 1 bit 0 output, rest input and high: set bit copies pin levels
		wrt(`PAFM_DIR_BASE + 8'h04, 32'hFE);
		dir[1] = 8'hFE;
		@(posedge clk);
		ext[15:8] <= 8'hFF;
		repeat (3) @(posedge clk);
		cmd(2'd1, 3'd0, 3'd0, 8'h00);
		wrt(`PAFM_DIR_BASE + 8'h04, 32'h00);
		dir[1] = 8'h00;
		check_all();
		// Every operation code on a half-input port
		wrt(`PAFM_DIR_BASE + 8'h08, 32'h0F);
		dir[2] = 8'h0F;
		for (int op = 0; op < 8; op++) begin
			d = $urandom;
			cmd(2'd2, d[2:0], 3'(op), d[15:8]);
			check_all();
		end
		// Peripheral outputs with the settings software must make
		rr = 1'b1;
		wrt(`PAFM_REROUTE_ADDR, 32'h04);
		for (int i = 0; i < 3; i++) begin
			wrt(`PAFM_LATCH_BASE + 8'(4 * i), 32'(al[i]));
			wrt(`PAFM_DIR_BASE + 8'(4 * i), 32'(ad[i]));
			lat[i] = al[i];
			dir[i] = ad[i];
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			aen <= 32'h0003_0203;
			aout <= $urandom;
			check_all();
		end
		// Unmapped, absent port and masked write are all harmless
		rdb(8'h60, q);
		chk(q, 32'h0);
		rdb(`PAFM_LATCH_BASE + 8'h10, q);
		chk(q, 32'h0);
		bus(1'b1, `PAFM_LATCH_BASE, 32'h5A, 4'h0, q);
		check_all();
		// Configuration copies of the analog selects
		for (int i = 0; i < 3; i++) begin
			d = $urandom;
			wrt(`PAFM_ANACFG_ADDR + 8'(4 * i), d);
			rdb(`PAFM_ANACFG_ADDR + 8'(4 * i), q);
			chk(q, {24'h0, d[7:0] & msk[i]});
			q = (i == 0) ? {27'h0, ana_o} : (i == 1) ? {24'h0, ch_o} : {29'h0, amp_o};
			chk(q, {24'h0, d[7:0] & msk[i]});
		end
		// Clock enable low must freeze the pin view handed to peripherals
		q = epad();
		@(posedge clk);
		ce <= 1'b0;
		ext <= ~ext;
		repeat (8) @(posedge clk);
		chk(ain, q);
		ce <= 1'b1;
		check_all();
		// Random traffic compared with the model after each action
		for (int i = 0; i < 120; i++) begin
			k = $urandom % 6;
			p = 2'($urandom);
			d = $urandom;
			case (k)
				0: begin
					wrt(`PAFM_LATCH_BASE + 8'(4 * p), 32'(d[7:0]));
					lat[p] = d[7:0];
				end
				1: begin
					wrt(`PAFM_DIR_BASE + 8'(4 * p), 32'(d[7:0]));
					dir[p] = d[7:0];
				end
				2: cmd(p, d[2:0], d[10:8], d[23:16]);
				3: begin
					@(posedge clk);
					ext <= d;
					aen <= $urandom;
					aout <= $urandom;
				end
				4: begin
					wrt(`PAFM_CLKMODE_ADDR, 32'(d[7:0]));
					cm = d[7:0];
				end
				default: begin
					wrt(`PAFM_REROUTE_ADDR, 32'(d[7:0]));
					rr = d[2];
				end
			endcase
			check_all();
		end
		// Reset in mid-run clears latches even of input pins
		for (int i = 0; i < 4; i++) begin
			wrt(`PAFM_LATCH_BASE + 8'(4 * i), 32'hFF);
		end
		do_rst();
		@(posedge clk);
		aen <= '0;
		for (int i = 0; i < 4; i++) begin
			wrt(`PAFM_DIR_BASE + 8'(4 * i), 32'h00);
			dir[i] = 8'h00;
		end
		check_all();
		end_sim();
	end
endmodule : tb
